// ### hw/asf_pkg.sv
// Package for the accumulator status flag block: widths, opcodes,
// register map, flag bit positions and user-memory ranges.
// Assumes a single clock domain and an APB master with 32-bit data.
`default_nettype none

package asf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned ACC_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned NIB_N = ACC_W / NIB_W;
  localparam int unsigned NUM_PRESETS = 24;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned MODE_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Operations reported by the execution unit
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_LOAD     = 4'h1,
    OP_LOAD_BCD = 4'h2,
    OP_LOAD_OCT = 4'h3,
    OP_CMP      = 4'h4,
    OP_ADD16    = 4'h5,
    OP_ADD32    = 4'h6,
    OP_SUB16    = 4'h7,
    OP_SUB32    = 4'h8
  } asf_op_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ACC = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_MODE = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_EQ = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_PRESET = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_PRESET_END = 12'h0a0;

  // Flag word bit positions
  localparam int unsigned FB_LT = 0;
  localparam int unsigned FB_EQ = 1;
  localparam int unsigned FB_GT = 2;
  localparam int unsigned FB_ZERO = 3;
  localparam int unsigned FB_HBORROW = 4;
  localparam int unsigned FB_BORROW = 5;
  localparam int unsigned FB_HCARRY = 6;
  localparam int unsigned FB_CARRY = 7;
  localparam int unsigned FB_SIGN = 8;
  localparam int unsigned FB_OCTAL = 9;
  localparam int unsigned FB_OVF = 10;
  localparam int unsigned FB_DATA = 11;
  localparam int unsigned FB_LZERO = 12;
  localparam int unsigned FB_PULSE = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
  localparam logic [MODE_W-1:0] MODE_EQ_CNT = 8'h0a;
  localparam logic [NIB_W-1:0] OCT_MAX = 4'h7;
  localparam logic [NIB_W-1:0] BCD_MAX = 4'h9;

  // Valid user-memory word ranges for pointers (octal 2000-2377, 4000-4177,
  // 7630-7647 as binary word addresses)
  localparam logic [ADDR_W-1:0] RAM_LO = 12'h400;
  localparam logic [ADDR_W-1:0] RAM_HI = 12'h4ff;
  localparam logic [ADDR_W-1:0] EE_LO = 12'h800;
  localparam logic [ADDR_W-1:0] EE_HI = 12'h87f;
  localparam logic [ADDR_W-1:0] EE2_LO = 12'hf98;
  localparam logic [ADDR_W-1:0] EE2_HI = 12'hfa7;

endpackage : asf_pkg

`default_nettype wire

// ### hw/asf_preset_cmp.sv
// Preset slot storage and the counter equality comparators.
// Assumes the caller keeps write and read indices below the slot count.
`default_nettype none

module asf_preset_cmp
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Slot access
  input wire logic wr_en_i,
  input wire logic [IDX_W-1:0] wr_idx_i,
  input wire logic [ACC_W-1:0] wr_data_i,
  input wire logic [IDX_W-1:0] rd_idx_i,
  output logic [ACC_W-1:0] rd_data_o,
  // Compare
  input wire logic enable_i,
  input wire logic [ACC_W-1:0] value_i,
  output logic [NUM_PRESETS-1:0] equal_o
);

  logic [ACC_W-1:0] preset_q [NUM_PRESETS];

  always_comb begin
    rd_data_o = ACC_RST;
    if (32'(rd_idx_i) < NUM_PRESETS) begin
      rd_data_o = preset_q[rd_idx_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One slot and one comparator per entry
  for (genvar g = 0; g < NUM_PRESETS; g++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        preset_q[g] <= ACC_RST;
      end else if (ce_i && wr_en_i && (32'(wr_idx_i) == g)) begin
        preset_q[g] <= wr_data_i;
      end
    end

    // Registered so the flags never glitch with the counter
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        equal_o[g] <= 1'b0;
      end else if (ce_i) begin
        equal_o[g] <= enable_i && (value_i == preset_q[g]);
      end
    end
  end

endmodule : asf_preset_cmp

`default_nettype wire

// ### hw/asf_flags.sv
// Accumulator status flags, fast-input pulse catch and counter equality
// flags, with an APB slave for readback and preset/mode setup.
// Assumes the execution unit pulses op_valid_i once per finished
// instruction and scan_end_i once per scan, all synchronous to clk_i.
//
// The implementer's own choices: register access over APB and the address map.
`default_nettype none

module asf_flags
  import asf_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ACC_W-1:0] pwdata_i,
  output logic [ACC_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Execution unit
  input wire logic op_valid_i,
  input wire asf_op_t op_i,
  input wire logic [ACC_W-1:0] operand_i,
  input wire logic ptr_chk_i,
  input wire logic [ADDR_W-1:0] ptr_addr_i,
  // Fast I/O unit
  input wire logic fast_input_zero_i,
  input wire logic scan_end_i,
  input wire logic [ACC_W-1:0] ctr_value_i,
  // Accumulator and flags
  output logic [ACC_W-1:0] acc_o,
  output logic less_than_flag_o,
  output logic equal_flag_o,
  output logic greater_than_flag_o,
  output logic zero_result_flag_o,
  output logic half_borrow_flag_o,
  output logic borrow_flag_o,
  output logic half_carry_flag_o,
  output logic carry_flag_o,
  output logic sign_flag_o,
  output logic invalid_octal_flag_o,
  output logic overflow_flag_o,
  output logic data_error_flag_o,
  output logic load_zero_flag_o,
  output logic pulse_catch_flag_o,
  output logic [NUM_PRESETS-1:0] counter_equal_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [ACC_W-1:0] acc_q, acc_d;
  logic res_wr, is_cmp, is_load;
  logic [HALF_W:0] sum16, dif16;
  logic [ACC_W:0] sum32, dif32;
  logic [NIB_N-1:0] oct_bad, bcd_bad;
  logic ovf_d, ptr_ok, fast_prev_q, seen_q, pulse_now;
  logic in_preset, addr_bad, ro_hit, apb_setup, apb_wr;
  logic [MODE_W-1:0] mode_q;
  logic [ACC_W-1:0] flags_word, rd_mux, preset_rd;
  logic [ADDR_W-1:0] preset_off;
  logic [IDX_W-1:0] preset_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic
  assign sum16 = {1'b0, acc_q[HALF_W-1:0]} + {1'b0, operand_i[HALF_W-1:0]};
  assign dif16 = {1'b0, acc_q[HALF_W-1:0]} - {1'b0, operand_i[HALF_W-1:0]};
  assign sum32 = {1'b0, acc_q} + {1'b0, operand_i};
  assign dif32 = {1'b0, acc_q} - {1'b0, operand_i};

  always_comb begin
    acc_d = acc_q;
    res_wr = 1'b0;
    ovf_d = 1'b0;
    is_cmp = 1'b0;
    is_load = 1'b0;
    if (op_valid_i) begin
      unique case (op_i)
        OP_LOAD, OP_LOAD_BCD, OP_LOAD_OCT: begin
          acc_d = operand_i;
          res_wr = 1'b1;
          is_load = 1'b1;
        end
        OP_CMP: is_cmp = 1'b1;
        OP_ADD16: begin
          // 16-bit ops leave the upper half clear
          acc_d = {{HALF_W{1'b0}}, sum16[HALF_W-1:0]};
          res_wr = 1'b1;
          ovf_d = (acc_q[HALF_W-1] == operand_i[HALF_W-1]) &&
                  (sum16[HALF_W-1] != acc_q[HALF_W-1]);
        end
        OP_ADD32: begin
          acc_d = sum32[ACC_W-1:0];
          res_wr = 1'b1;
          ovf_d = (acc_q[ACC_W-1] == operand_i[ACC_W-1]) &&
                  (sum32[ACC_W-1] != acc_q[ACC_W-1]);
        end
        OP_SUB16: begin
          acc_d = {{HALF_W{1'b0}}, dif16[HALF_W-1:0]};
          res_wr = 1'b1;
          ovf_d = (acc_q[HALF_W-1] != operand_i[HALF_W-1]) &&
                  (dif16[HALF_W-1] != acc_q[HALF_W-1]);
        end
        OP_SUB32: begin
          acc_d = dif32[ACC_W-1:0];
          res_wr = 1'b1;
          ovf_d = (acc_q[ACC_W-1] != operand_i[ACC_W-1]) &&
                  (dif32[ACC_W-1] != acc_q[ACC_W-1]);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_q <= ACC_RST;
    end else if (ce_i) begin
      acc_q <= acc_d;
    end
  end

  assign acc_o = acc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Operand digit checks, one per nibble
  for (genvar g = 0; g < NIB_N; g++) begin : g_nib
    assign oct_bad[g] = operand_i[g*NIB_W +: NIB_W] > OCT_MAX;
    assign bcd_bad[g] = operand_i[g*NIB_W +: NIB_W] > BCD_MAX;
  end

  assign ptr_ok = ((ptr_addr_i >= RAM_LO) && (ptr_addr_i <= RAM_HI)) ||
                  ((ptr_addr_i >= EE_LO) && (ptr_addr_i <= EE_HI)) ||
                  ((ptr_addr_i >= EE2_LO) && (ptr_addr_i <= EE2_HI));

  ////////////////////////////////////////////////////////////////////////////
  // Compare flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      less_than_flag_o <= 1'b0;
      equal_flag_o <= 1'b0;
      greater_than_flag_o <= 1'b0;
    end else if (ce_i && is_cmp) begin
      less_than_flag_o <= acc_q < operand_i;
      equal_flag_o <= acc_q == operand_i;
      greater_than_flag_o <= acc_q > operand_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and load flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      zero_result_flag_o <= 1'b0;
    end else if (ce_i && res_wr) begin
      zero_result_flag_o <= acc_d == ACC_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      load_zero_flag_o <= 1'b0;
    end else if (ce_i && is_load) begin
      load_zero_flag_o <= operand_i == ACC_RST;
    end
  end

  // Tracks the accumulator every cycle, not just on completion
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sign_flag_o <= 1'b0;
    end else if (ce_i) begin
      sign_flag_o <= acc_d[ACC_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry, borrow and overflow flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      half_carry_flag_o <= 1'b0;
      carry_flag_o <= 1'b0;
      half_borrow_flag_o <= 1'b0;
      borrow_flag_o <= 1'b0;
    end else if (ce_i && op_valid_i) begin
      if (op_i == OP_ADD16) half_carry_flag_o <= sum16[HALF_W];
      if (op_i == OP_ADD32) carry_flag_o <= sum32[ACC_W];
      if (op_i == OP_SUB16) half_borrow_flag_o <= dif16[HALF_W];
      if (op_i == OP_SUB32) borrow_flag_o <= dif32[ACC_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      overflow_flag_o <= 1'b0;
    end else if (ce_i && res_wr && !is_load) begin
      overflow_flag_o <= ovf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand format flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_error_flag_o <= 1'b0;
    end else if (ce_i && op_valid_i && (op_i == OP_LOAD_BCD)) begin
      data_error_flag_o <= |bcd_bad;
    end
  end

  // A pointer check and an octal load in one cycle both count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      invalid_octal_flag_o <= 1'b0;
    end else if (ce_i && (ptr_chk_i || (op_valid_i && (op_i == OP_LOAD_OCT)))) begin
      invalid_octal_flag_o <= (ptr_chk_i && !ptr_ok) ||
        (op_valid_i && (op_i == OP_LOAD_OCT) && (|oct_bad));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse catch on the first fast input
  assign pulse_now = fast_input_zero_i && !fast_prev_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fast_prev_q <= 1'b0;
    end else if (ce_i) begin
      fast_prev_q <= fast_input_zero_i;
    end
  end

  // An edge on the strobe cycle goes straight into this scan's flag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      seen_q <= 1'b0;
    end else if (ce_i) begin
      if (scan_end_i) seen_q <= 1'b0;
      else if (pulse_now) seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pulse_catch_flag_o <= 1'b0;
    end else if (ce_i && scan_end_i) begin
      pulse_catch_flag_o <= seen_q || pulse_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter preset slots and equality flags
  asf_preset_cmp asf_preset_cmp_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .wr_en_i(apb_wr && in_preset),
    .wr_idx_i(preset_idx),
    .wr_data_i(pwdata_i),
    .rd_idx_i(preset_idx),
    .rd_data_o(preset_rd),
    .enable_i(mode_q == MODE_EQ_CNT),
    .value_i(ctr_value_i),
    .equal_o(counter_equal_flag_o)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_q <= MODE_RST;
    end else if (ce_i && apb_wr && (paddr_i == OFS_MODE)) begin
      mode_q <= pwdata_i[MODE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign preset_off = paddr_i - OFS_PRESET;
  assign preset_idx = preset_off[IDX_LSB +: IDX_W];
  assign in_preset = (paddr_i >= OFS_PRESET) && (paddr_i < OFS_PRESET_END);
  assign ro_hit = (paddr_i == OFS_FLAGS) || (paddr_i == OFS_ACC) ||
                  (paddr_i == OFS_EQ);
  assign apb_setup = psel_i && !penable_i && !pready_o;
  assign apb_wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

  always_comb begin
    flags_word = ACC_RST;
    flags_word[FB_LT] = less_than_flag_o;
    flags_word[FB_EQ] = equal_flag_o;
    flags_word[FB_GT] = greater_than_flag_o;
    flags_word[FB_ZERO] = zero_result_flag_o;
    flags_word[FB_HBORROW] = half_borrow_flag_o;
    flags_word[FB_BORROW] = borrow_flag_o;
    flags_word[FB_HCARRY] = half_carry_flag_o;
    flags_word[FB_CARRY] = carry_flag_o;
    flags_word[FB_SIGN] = sign_flag_o;
    flags_word[FB_OCTAL] = invalid_octal_flag_o;
    flags_word[FB_OVF] = overflow_flag_o;
    flags_word[FB_DATA] = data_error_flag_o;
    flags_word[FB_LZERO] = load_zero_flag_o;
    flags_word[FB_PULSE] = pulse_catch_flag_o;
  end

  always_comb begin
    rd_mux = ACC_RST;
    addr_bad = 1'b0;
    if (paddr_i[IDX_LSB-1:0] != '0) begin
      addr_bad = 1'b1;
    end else if (paddr_i == OFS_FLAGS) begin
      rd_mux = flags_word;
    end else if (paddr_i == OFS_ACC) begin
      rd_mux = acc_q;
    end else if (paddr_i == OFS_MODE) begin
      rd_mux = {{(ACC_W-MODE_W){1'b0}}, mode_q};
    end else if (paddr_i == OFS_EQ) begin
      rd_mux = {{(ACC_W-NUM_PRESETS){1'b0}}, counter_equal_flag_o};
    end else if (in_preset) begin
      rd_mux = preset_rd;
    end else begin
      addr_bad = 1'b1;
    end
  end

  // One wait-free access phase; answer registered at the setup edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= ACC_RST;
    end else if (ce_i) begin
      if (apb_setup) begin
        pready_o <= 1'b1;
        pslverr_o <= addr_bad || (pwrite_i && ro_hit);
        prdata_o <= pwrite_i ? ACC_RST : rd_mux;
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o <= ACC_RST;
      end
    end
  end

endmodule : asf_flags

`default_nettype wire

// ### bench/asf_flags_checker.sv
// Checker: port assertions for the accumulator status flag block.
// Assumes it is bound to asf_flags and sees only that module's ports.
`default_nettype none

module asf_flags_checker
  import asf_pkg::*;
(
  // Watched ports
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire asf_op_t op_i,
  input wire logic [ACC_W-1:0] operand_i,
  input wire logic scan_end_i,
  input wire logic [ACC_W-1:0] acc_o,
  input wire logic less_than_flag_o,
  input wire logic equal_flag_o,
  input wire logic zero_result_flag_o,
  input wire logic borrow_flag_o,
  input wire logic carry_flag_o,
  input wire logic sign_flag_o,
  input wire logic load_zero_flag_o,
  input wire logic pulse_catch_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic take;
  logic [ACC_W:0] sum;
  assign take = ce_i & op_valid_i;
  assign sum = {1'b0, acc_o} + {1'b0, operand_i};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  //////////////////////////////////////////////////////////////////////////////
  a_sign_tracks: assert property (sign_flag_o == acc_o[ACC_W-1])
    else $error("sign flag differs from accumulator");
  a_less_than: assert property (take && op_i == OP_CMP |=>
    less_than_flag_o == ($past(acc_o) < $past(operand_i))) else $error("less-than wrong");
  a_equal_cmp: assert property (take && op_i == OP_CMP |=>
    equal_flag_o == ($past(acc_o) == $past(operand_i))) else $error("equal wrong");
  a_zero_result: assert property (take && op_i != OP_NONE && op_i != OP_CMP |=>
    zero_result_flag_o == (acc_o == '0)) else $error("zero flag wrong");
  a_load_zero: assert property (take && op_i inside {[OP_LOAD:OP_LOAD_OCT]} |=>
    load_zero_flag_o == ($past(operand_i) == '0)) else $error("load-zero wrong");
  a_carry_out: assert property (take && op_i == OP_ADD32 |=>
    carry_flag_o == $past(sum[ACC_W])) else $error("carry wrong");
  a_borrow_out: assert property (take && op_i == OP_SUB32 |=>
    borrow_flag_o == ($past(acc_o) < $past(operand_i))) else $error("borrow wrong");
  a_cmp_hold: assert property (!(take && op_i == OP_CMP) |=>
    $stable(less_than_flag_o) && $stable(equal_flag_o)) else $error("compare flags moved");
  a_pulse_boundary: assert property ($rose(pulse_catch_flag_o) |-> $past(scan_end_i))
    else $error("pulse flag rose off a boundary");
  a_pulse_stays: assert property (pulse_catch_flag_o && !scan_end_i |=>
    pulse_catch_flag_o) else $error("pulse flag dropped mid-scan");

  c_compare: cover property (take && op_i == OP_CMP);
  c_carry: cover property (take && op_i == OP_ADD32 && sum[ACC_W]);
  c_pulse: cover property ($rose(pulse_catch_flag_o));

endmodule : asf_flags_checker

bind asf_flags asf_flags_checker asf_flags_checker_i (
  .clk_i, .srst_i, .ce_i, .op_valid_i, .op_i, .operand_i, .scan_end_i, .acc_o,
  .less_than_flag_o, .equal_flag_o, .zero_result_flag_o, .borrow_flag_o,
  .carry_flag_o, .sign_flag_o, .load_zero_flag_o, .pulse_catch_flag_o
);

`default_nettype wire

// ### bench/asf_exec_model.sv
// Execution unit model: issues instructions and pointer checks, and notes
// the accumulator and flag word each one should leave behind.
// Assumes one reset at the start, which clears the block to zero.
`default_nettype none

module asf_exec_model
  import asf_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Requests to the flag block
  output logic op_valid_o,
  output asf_op_t op_o,
  output logic [ACC_W-1:0] operand_o,
  output logic ptr_chk_o,
  output logic [ADDR_W-1:0] ptr_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [ACC_W-1:0] acc = '0;
  logic [12:0] flg = '0;
  logic [ACC_W+12:0] exp_q [$];

  initial begin
    op_valid_o = 1'b0;
    op_o = OP_NONE;
    operand_o = '0;
    ptr_chk_o = 1'b0;
    ptr_addr_o = '0;
  end

  function automatic logic nib_over(input logic [ACC_W-1:0] v, input logic [3:0] m);
    nib_over = 1'b0;
    for (int i = 0; i < NIB_N; i++) if (v[4*i+:4] > m) nib_over = 1'b1;
  endfunction : nib_over

  //////////////////////////////////////////////////////////////////////////////
  // Flags not touched by an op keep their note value
  task automatic run_op(input asf_op_t op, input logic [ACC_W-1:0] v);
    logic [ACC_W:0] r;
    logic [ACC_W-1:0] a;
    a = acc;
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_o <= op;
    operand_o <= v;
    ptr_chk_o <= 1'b0;
    case (op)
      OP_LOAD, OP_LOAD_BCD, OP_LOAD_OCT: begin
        acc = v;
        flg[FB_LZERO] = (v == '0);
        if (op == OP_LOAD_BCD) flg[FB_DATA] = nib_over(v, BCD_MAX);
        if (op == OP_LOAD_OCT) flg[FB_OCTAL] = nib_over(v, OCT_MAX);
      end
      OP_CMP: begin
        flg[FB_LT] = a < v;
        flg[FB_EQ] = a == v;
        flg[FB_GT] = a > v;
      end
      OP_ADD16, OP_SUB16: begin
        r = (op == OP_ADD16) ? a[15:0] + v[15:0] : a[15:0] - v[15:0];
        acc = {16'h0, r[15:0]};
        flg[op == OP_ADD16 ? FB_HCARRY : FB_HBORROW] = r[16];
        flg[FB_OVF] = (a[15] ^ r[15]) & (a[15] ^ v[15] ^ (op == OP_ADD16));
      end
      OP_ADD32, OP_SUB32: begin
        r = (op == OP_ADD32) ? a + v : a - v;
        acc = r[ACC_W-1:0];
        flg[op == OP_ADD32 ? FB_CARRY : FB_BORROW] = r[ACC_W];
        flg[FB_OVF] = (a[31] ^ r[31]) & (a[31] ^ v[31] ^ (op == OP_ADD32));
      end
      default: ;
    endcase
    if (op != OP_NONE && op != OP_CMP) flg[FB_ZERO] = (acc == '0);
    flg[FB_SIGN] = acc[ACC_W-1];
    exp_q.push_back({acc, flg});
  endtask : run_op

  task automatic ptr(input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    ptr_chk_o <= 1'b1;
    ptr_addr_o <= a;
    flg[FB_OCTAL] = !(a inside {[RAM_LO:RAM_HI], [EE_LO:EE_HI], [EE2_LO:EE2_HI]});
    exp_q.push_back({acc, flg});
  endtask : ptr

  task automatic idle();
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    ptr_chk_o <= 1'b0;
  endtask : idle

endmodule : asf_exec_model

`default_nettype wire

// ### bench/asf_flags_tb_top.sv
// Testbench for the accumulator status flag block.
// Assumes asf_exec_model drives the instruction side and queues results.
`default_nettype none

module asf_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;

  logic clk_i = 1'b0;
  logic srst_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic op_valid_i, ptr_chk_i, fast_input_zero_i, scan_end_i;
  asf_op_t op_i;
  logic [ADDR_W-1:0] paddr_i, ptr_addr_i;
  logic [ACC_W-1:0] pwdata_i, prdata_o, operand_i, ctr_value_i, acc_o, rd, pv;
  logic less_than_flag_o, equal_flag_o, greater_than_flag_o, zero_result_flag_o;
  logic half_borrow_flag_o, borrow_flag_o, half_carry_flag_o, carry_flag_o;
  logic sign_flag_o, invalid_octal_flag_o, overflow_flag_o, data_error_flag_o;
  logic load_zero_flag_o, pulse_catch_flag_o;
  logic [NUM_PRESETS-1:0] counter_equal_flag_o;
  logic [12:0] flags;
  logic [ACC_W+12:0] exp_w;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 88;

  asf_flags asf_flags_i (
    .clk_i, .srst_i, .ce_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .op_valid_i, .op_i, .operand_i, .ptr_chk_i,
    .ptr_addr_i, .fast_input_zero_i, .scan_end_i, .ctr_value_i, .acc_o,
    .less_than_flag_o, .equal_flag_o, .greater_than_flag_o, .zero_result_flag_o,
    .half_borrow_flag_o, .borrow_flag_o, .half_carry_flag_o, .carry_flag_o,
    .sign_flag_o, .invalid_octal_flag_o, .overflow_flag_o, .data_error_flag_o,
    .load_zero_flag_o, .pulse_catch_flag_o, .counter_equal_flag_o
  );

  asf_exec_model asf_exec_model_i (
    .clk_i, .op_valid_o(op_valid_i), .op_o(op_i), .operand_o(operand_i),
    .ptr_chk_o(ptr_chk_i), .ptr_addr_o(ptr_addr_i)
  );

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Request held until pready is sampled high; no wait state expected
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    check(n == 1, "apb wait state");
  endtask : apb

  task automatic reg_chk(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                         input logic [31:0] x, input logic xe);
    apb(w, a, d);
    check(er === xe && (w || rd === x), "apb response");
  endtask : reg_chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic scan(input logic f);
    @(posedge clk_i);
    scan_end_i <= 1'b1;
    fast_input_zero_i <= f;
    @(posedge clk_i) scan_end_i <= 1'b0;
    #1;
  endtask : scan

  //////////////////////////////////////////////////////////////////////////////
  // Every op or pointer check leaves one note; the result is visible one edge on
  assign flags = {load_zero_flag_o, data_error_flag_o, overflow_flag_o,
    invalid_octal_flag_o, sign_flag_o, carry_flag_o, half_carry_flag_o, borrow_flag_o,
    half_borrow_flag_o, zero_result_flag_o, greater_than_flag_o, equal_flag_o,
    less_than_flag_o};
  always @(posedge clk_i) begin
    if (op_valid_i === 1'b1 || ptr_chk_i === 1'b1) begin
      #1;
      exp_w = asf_exec_model_i.exp_q.pop_front();
      check({acc_o, flags} === exp_w, "acc or flags");
    end
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    static asf_op_t dop [18] = '{OP_LOAD, OP_LOAD_BCD, OP_LOAD_BCD, OP_LOAD_OCT, OP_LOAD_OCT,
      OP_LOAD, OP_ADD32, OP_SUB32, OP_CMP, OP_CMP, OP_LOAD, OP_ADD16, OP_SUB16,
      OP_ADD16, OP_CMP, OP_NONE, OP_LOAD, OP_SUB32};
    static logic [31:0] dv [18] = '{32'h0, 32'h9876_5432, 32'ha0, 32'h7654_3210, 32'h8,
      32'hffff_ffff, 32'h1, 32'h1, 32'hffff_ffff, 32'h0, 32'h7fff, 32'h1, 32'h8001,
      32'h1, 32'hffff_ffff, 32'h5, 32'h8000_0000, 32'h1};
    logic [3:0] k;
    srst_i = 1'b1;
    ce_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = '0;
    pwdata_i = '0;
    fast_input_zero_i = 1'b0;
    scan_end_i = 1'b0;
    ctr_value_i = '0;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    reg_chk(0, OFS_FLAGS, '0, '0, 0);
    reg_chk(0, OFS_MODE, '0, '0, 0);
    for (int i = 0; i < 18; i++) asf_exec_model_i.run_op(dop[i], dv[i]);
    for (int i = 0; i < 40; i++) begin
      k = 4'($unsigned($random(seed)) % 9);
      asf_exec_model_i.run_op(asf_op_t'(k), $random(seed));
      if ($random(seed) % 4 == 0) asf_exec_model_i.idle();
    end
    asf_exec_model_i.ptr(12'hfa8);
    asf_exec_model_i.ptr(12'h400);
    asf_exec_model_i.ptr(12'h3ff);
    asf_exec_model_i.ptr(12'hfa7);
    asf_exec_model_i.idle();
    pv = asf_exec_model_i.acc;
    reg_chk(1, OFS_ACC, 32'h1234, '0, 1);
    reg_chk(1, OFS_FLAGS, '1, '0, 1);
    reg_chk(0, OFS_ACC, '0, pv, 0);
    reg_chk(0, OFS_FLAGS, '0, {19'h0, asf_exec_model_i.flg}, 0);
    reg_chk(0, OFS_PRESET_END, '0, '0, 1);
    reg_chk(0, 12'h002, '0, '0, 1);
    pv = ($random(seed) | 32'h1) & 32'h7fff_ffff;
    reg_chk(1, OFS_PRESET, pv, '0, 0);
    reg_chk(1, OFS_PRESET + 12'h05c, ~pv, '0, 0);
    reg_chk(0, OFS_PRESET + 12'h05c, '0, ~pv, 0);
    ctr_value_i <= pv;
    tick(2);
    check(counter_equal_flag_o === '0, "eq flags outside mode");
    reg_chk(1, OFS_MODE, {24'h0, MODE_EQ_CNT}, '0, 0);
    tick(2);
    check(counter_equal_flag_o === 24'h00_0001, "first eq flag");
    @(posedge clk_i) ctr_value_i <= ~pv;
    tick(2);
    check(counter_equal_flag_o === 24'h80_0000, "last eq flag");
    reg_chk(0, OFS_EQ, '0, 32'h0080_0000, 0);
    fast_input_zero_i <= 1'b1;
    tick(3);
    check(pulse_catch_flag_o === 1'b0, "pulse early");
    scan(1'b1);
    check(pulse_catch_flag_o === 1'b1, "pulse caught");
    tick(4);
    check(pulse_catch_flag_o === 1'b1, "pulse held");
    scan(1'b1);
    check(pulse_catch_flag_o === 1'b0, "pulse one scan");
    scan(1'b0);
    scan(1'b1);
    check(pulse_catch_flag_o === 1'b1, "pulse on boundary");
    end_of_test();
  end

endmodule : asf_flags_tb_top

`default_nettype wire
